/* File: ccsr_cfg.svh */
`ifndef CCSR_CFG_SVH
`define CCSR_CFG_SVH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define CCSR_ADDR_STATUS 8'h82
`define CCSR_ADDR_CTRL 8'h83
`define CCSR_ADDR_BUF_FIRST 8'h84
`define CCSR_ADDR_BUF_LAST 8'h93
`define CCSR_ADDR_CTRL_ALIAS 8'h94

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CCSR_BIT_FAULT 7
`define CCSR_BIT_DONE 0
`define CCSR_BIT_START 7
`define CCSR_MODE_HI 6
`define CCSR_MODE_LO 4
`define CCSR_BIT_DIR 3
`define CCSR_CTRL_RESET 8'h00
`define CCSR_STATUS_RESET 8'h00
`define CCSR_BUF_BYTES 16

// ----------------------------------------------------------------
// SPI framing and timing
// ----------------------------------------------------------------
`define CCSR_CMD_SRAM_WRITE 3'b010
`define CCSR_CMD_SRAM_READ 3'b000
`define CCSR_RUN_TIME_NS 24000
`define CCSR_CLK_PERIOD_NS 40
`define CCSR_RUN_CYCLES ((`CCSR_RUN_TIME_NS + `CCSR_CLK_PERIOD_NS - 1) / `CCSR_CLK_PERIOD_NS)

`endif

/* File: ccsr_checker.sv */
`include "ccsr_cfg.svh"

// ----------------------------------------------------------------
// Port checker for the cipher control block
// ----------------------------------------------------------------
module ccsr_checker
#(
    parameter int RUN_CYCLES = `CCSR_RUN_CYCLES
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SLEEP,
    input wire logic SCLK,
    input wire logic SEL_N,
    input wire logic MOSI,
    input wire logic MISO,
    input wire logic MISO_OE,
    input wire logic [2:0] CIPHER_OP,
    input wire logic CIPHER_DECRYPT,
    input wire logic CIPHER_BUSY
);
    logic [15:0] busy_cnt_r;
    logic [15:0] busy_cnt_nxt;

    // Busy length; a restart while busy would not reset it
    always_comb
    begin
        busy_cnt_nxt = CIPHER_BUSY ? busy_cnt_r + 16'h0001 : 16'h0000;
    end

    always_ff @(posedge CLK)
    begin
        busy_cnt_r <= RST_N ? busy_cnt_nxt : 16'h0000;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // Host idle, and no sleep now or just before
    sequence s_idle;
        SEL_N [*6];
    endsequence
    sequence s_awake;
        !SLEEP && !$past(SLEEP);
    endsequence

    a_decrypt_ecb_only: assert property (CIPHER_DECRYPT |-> CIPHER_OP == 3'h0)
        else $error("decrypt outside ECB");
    a_sleep_clears: assert property (SLEEP |=> !CIPHER_BUSY && CIPHER_OP == 3'h0 && !CIPHER_DECRYPT)
        else $error("sleep left state set");
    a_run_max: assert property (CIPHER_BUSY |-> busy_cnt_r < RUN_CYCLES)
        else $error("run too long");
    a_run_full: assert property (($fell(CIPHER_BUSY) ##0 s_awake ##0 SEL_N) |-> busy_cnt_r == RUN_CYCLES)
        else $error("run ended early");
    a_start_in_frame: assert property ($rose(CIPHER_BUSY) |-> !SEL_N)
        else $error("run started outside a frame");
    a_ctrl_idle: assert property ((s_idle ##0 s_awake) |-> $stable(CIPHER_OP) && $stable(CIPHER_DECRYPT))
        else $error("control changed while idle");
    a_oe_idle: assert property (s_idle |-> !MISO_OE)
        else $error("output driven while deselected");
    a_oe_frame: assert property ($fell(SEL_N) |-> ##[1:3] MISO_OE)
        else $error("output not driven in frame");
    a_miso_hold: assert property (SCLK [*3] |-> $stable(MISO))
        else $error("serial output moved while clock high");
endmodule

bind ccsr_top ccsr_checker u_chk
(
    .CLK(CLK), .RST_N(RST_N), .SLEEP(SLEEP), .SCLK(SCLK), .SEL_N(SEL_N), .MOSI(MOSI),
    .MISO(MISO), .MISO_OE(MISO_OE), .CIPHER_OP(CIPHER_OP),
    .CIPHER_DECRYPT(CIPHER_DECRYPT), .CIPHER_BUSY(CIPHER_BUSY)
);

/* File: ccsr_host.sv */
// ----------------------------------------------------------------
// Host model: serial master, mode 0, link clock 320 ns
// ----------------------------------------------------------------
module ccsr_host
(
    input wire logic CLK,
    input wire logic MISO,
    output logic SCLK,
    output logic SEL_N,
    output logic MOSI,
    output logic [7:0] rx_byte,
    output logic rx_stb
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock stands low outside frames
    initial
    begin
        SCLK = 1'b0;
        SEL_N = 1'b1;
        MOSI = 1'b0;
        rx_byte = 8'h00;
        rx_stb = 1'b0;
    end

    task automatic open_frame();
        @(posedge CLK);
        SEL_N <= 1'b0;
        repeat (4) @(posedge CLK);
    endtask

    // Released data line shows the inverse of its last bit
    task automatic close_frame();
        repeat (4) @(posedge CLK);
        SEL_N <= 1'b1;
        MOSI <= ~MOSI;
        repeat (4) @(posedge CLK);
    endtask

    // MSB first; shift on the fall, sample on the rise
    task automatic xbyte(input logic [7:0] tx);
        logic [7:0] rx;
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge CLK);
            SCLK <= 1'b0;
            MOSI <= tx[i];
            repeat (4) @(posedge CLK);
            SCLK <= 1'b1;
            rx[i] = MISO;
            repeat (3) @(posedge CLK);
        end
        @(posedge CLK);
        SCLK <= 1'b0;
        rx_byte <= rx;
        rx_stb <= 1'b1;
        @(posedge CLK);
        rx_stb <= 1'b0;
    endtask
endmodule

/* File: ccsr_pkg.sv */
package ccsr_pkg;

    // Operation select field encodings
    typedef enum logic [2:0]
    {
        CCSR_OP_ECB = 3'h0,
        CCSR_OP_KEY = 3'h1,
        CCSR_OP_CBC = 3'h2
    } ccsr_op_type;

    // Serial frame phases
    typedef enum logic [1:0]
    {
        CCSR_PH_CMD = 2'b00,
        CCSR_PH_ADDR = 2'b01,
        CCSR_PH_DATA = 2'b10,
        CCSR_PH_SKIP = 2'b11
    } ccsr_phase_type;

endpackage

/* File: ccsr_sync.sv */
`include "ccsr_cfg.svh"

// Two-stage synchroniser for pins arriving from outside the clock domain
module ccsr_sync
#(
    parameter logic RESET_VAL = 1'b0
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic pin_in,
    output logic pin_out
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    // First stage feeds only the second
    always_comb
    begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end

    // Register both stages
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            // Reset to the pin's idle level so no false event follows reset
            meta_r <= RESET_VAL;
            sync_r <= RESET_VAL;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign pin_out = sync_r;
endmodule

/* File: ccsr_timer.sv */
`include "ccsr_cfg.svh"

// Run timer: counts the block processing time after a start
module ccsr_timer
import ccsr_pkg::*;
#(
    parameter int RUN_CYCLES = `CCSR_RUN_CYCLES
)
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic start,
    input wire logic abort,
    output logic busy,
    output logic done_pulse
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic done_r;
    logic done_nxt;

    // Abort wins over completion; a start reloads even when busy
    always_comb
    begin
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (start)
        begin
            cnt_nxt = 16'(RUN_CYCLES - 1);
            busy_nxt = 1'b1;
        end
        else if (abort)
        begin
            busy_nxt = 1'b0;
        end
        else if (busy_r)
        begin
            if (cnt_r == 16'h0000)
            begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r - 16'h0001;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            cnt_r <= 16'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = busy_r;
    assign done_pulse = done_r;
endmodule

/* File: ccsr_top.sv */
`include "ccsr_cfg.svh"

module ccsr_top
import ccsr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SLEEP,
    input wire logic SCLK,
    input wire logic SEL_N,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE,
    output logic [2:0] CIPHER_OP,
    output logic CIPHER_DECRYPT,
    output logic CIPHER_BUSY
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic sclk_s;
    logic sel_n_s;
    logic mosi_s;
    logic sclk_d_r;
    logic sclk_d_nxt;

    ccsr_sync u_sync_sclk (.CLK(CLK), .RST_N(RST_N), .pin_in(SCLK), .pin_out(sclk_s));
    // Select idles high, so its stages reset deselected
    ccsr_sync #(.RESET_VAL(1'b1)) u_sync_sel
    (
        .CLK(CLK), .RST_N(RST_N), .pin_in(SEL_N), .pin_out(sel_n_s)
    );
    ccsr_sync u_sync_mosi (.CLK(CLK), .RST_N(RST_N), .pin_in(MOSI), .pin_out(mosi_s));

    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign sclk_fall = ~sclk_s & sclk_d_r;
    assign sclk_d_nxt = sclk_s;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [2:0] op_r;
    logic [2:0] op_nxt;
    logic dir_r;
    logic dir_nxt;
    logic fault_r;
    logic fault_nxt;
    logic done_r;
    logic done_nxt;
    logic [7:0] key_mem [0:`CCSR_BUF_BYTES-1];
    logic [7:0] data_mem [0:`CCSR_BUF_BYTES-1];

    // ----------------------------------------------------------------
    // Serial framing state
    // ----------------------------------------------------------------
    ccsr_phase_type ph_r;
    ccsr_phase_type ph_nxt;
    logic [2:0] bit_r;
    logic [2:0] bit_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic wr_r;
    logic wr_nxt;
    logic [7:0] out_r;
    logic [7:0] out_nxt;
    logic miso_r;
    logic miso_nxt;
    logic [4:0] rd_cnt_r;
    logic [4:0] rd_cnt_nxt;

    // Byte completion and access strobes
    logic byte_done;
    logic [7:0] rx_byte;
    logic acc;
    logic is_ctrl;
    logic in_buf;
    logic [3:0] buf_idx;
    logic start;
    logic abort;
    logic busy;
    logic done_pulse;
    logic buf_wr;
    logic in_sleep;

    assign in_sleep = SLEEP;
    assign rx_byte = {sh_r[6:0], mosi_s};
    assign byte_done = sclk_rise && !sel_n_s && (bit_r == 3'h7);
    assign acc = byte_done && (ph_r == CCSR_PH_DATA);
    assign buf_idx = addr_r[3:0] - 4'h4;

    // Control and its alias share one decode
    function automatic logic ctrl_hit(input logic [7:0] a);
        ctrl_hit = (a == `CCSR_ADDR_CTRL) || (a == `CCSR_ADDR_CTRL_ALIAS);
    endfunction

    // Read value for any address in the cipher space
    function automatic logic [7:0] read_val(input logic [7:0] a);
        logic [3:0] i;
        i = a[3:0] - 4'h4;
        read_val = 8'h00;
        if (a == `CCSR_ADDR_STATUS)
            read_val = {fault_r, 6'h00, done_r};
        else if (ctrl_hit(a))
            read_val = {1'b0, op_r, dir_r, 3'h0};
        else if (a >= `CCSR_ADDR_BUF_FIRST && a <= `CCSR_ADDR_BUF_LAST)
            read_val = (op_r == CCSR_OP_KEY) ? key_mem[i] : data_mem[i];
    endfunction

    assign is_ctrl = ctrl_hit(addr_r);
    assign in_buf = (addr_r >= `CCSR_ADDR_BUF_FIRST) && (addr_r <= `CCSR_ADDR_BUF_LAST);
    assign start = acc && wr_r && is_ctrl && rx_byte[`CCSR_BIT_START];
    assign abort = acc && is_ctrl && busy && !start;
    assign buf_wr = acc && wr_r && in_buf;

    // Any control access while busy stops the run; a start reloads it
    ccsr_timer u_timer
    (
        .CLK(CLK),
        .RST_N(RST_N && !in_sleep),
        .start(start),
        .abort(abort || (acc && is_ctrl && busy)),
        .busy(busy),
        .done_pulse(done_pulse)
    );

    // ----------------------------------------------------------------
    // Serial framing next state
    // ----------------------------------------------------------------
    always_comb
    begin
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        addr_nxt = addr_r;
        wr_nxt = wr_r;
        out_nxt = out_r;
        miso_nxt = miso_r;
        rd_cnt_nxt = rd_cnt_r;
        if (sel_n_s)
        begin
            ph_nxt = CCSR_PH_CMD;
            bit_nxt = 3'h0;
            miso_nxt = 1'b0;
        end
        else
        begin
            if (sclk_fall)
            begin
                // Shift out on the falling edge, MSB first
                miso_nxt = out_r[7];
                out_nxt = {out_r[6:0], 1'b0};
            end
            if (sclk_rise)
            begin
                sh_nxt = rx_byte;
                bit_nxt = bit_r + 3'h1;
            end
            if (byte_done)
            begin
                unique case (ph_r)
                    CCSR_PH_CMD:
                    begin
                        wr_nxt = (rx_byte[7:5] == `CCSR_CMD_SRAM_WRITE);
                        ph_nxt = (rx_byte[7:5] == `CCSR_CMD_SRAM_WRITE ||
                                  rx_byte[7:5] == `CCSR_CMD_SRAM_READ) ?
                                 CCSR_PH_ADDR : CCSR_PH_SKIP;
                        // Status shifts out during the address byte
                        out_nxt = {fault_r, 6'h00, done_r};
                    end
                    CCSR_PH_ADDR:
                    begin
                        addr_nxt = rx_byte;
                        ph_nxt = CCSR_PH_DATA;
                        // First byte of a read returns the register at once
                        out_nxt = wr_r ? 8'h00 : read_val(rx_byte);
                    end
                    CCSR_PH_DATA:
                    begin
                        addr_nxt = addr_r + 8'h01;
                        // Old content goes out one byte behind the write
                        out_nxt = read_val(wr_r ? addr_r : (addr_r + 8'h01));
                    end
                    CCSR_PH_SKIP:
                    begin
                        out_nxt = 8'h00;
                    end
                endcase
            end
        end
        // Count buffer reads; leaving early is a short read
        if (acc && !wr_r && in_buf)
            rd_cnt_nxt = rd_cnt_r + 5'h01;
        else if ((acc && !in_buf) || sel_n_s)
            rd_cnt_nxt = 5'h00;
    end

    // ----------------------------------------------------------------
    // Register file next state
    // ----------------------------------------------------------------
    logic short_read;
    assign short_read = (rd_cnt_r != 5'h00) && (rd_cnt_r < 5'(`CCSR_BUF_BYTES)) &&
                        ((acc && !in_buf) || sel_n_s);

    always_comb
    begin
        op_nxt = op_r;
        dir_nxt = dir_r;
        fault_nxt = fault_r;
        done_nxt = done_r;
        if (acc && wr_r && is_ctrl)
        begin
            op_nxt = rx_byte[`CCSR_MODE_HI:`CCSR_MODE_LO];
            dir_nxt = rx_byte[`CCSR_BIT_DIR];
        end
        if (start)
            done_nxt = 1'b0;
        if (done_pulse)
            done_nxt = 1'b1;
        if (acc && is_ctrl && busy)
            fault_nxt = 1'b1;
        if (short_read)
            fault_nxt = 1'b1;
    end

    // ----------------------------------------------------------------
    // Registers; sleep acts as a synchronous clear
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N || in_sleep)
        begin
            op_r <= 3'h0;
            dir_r <= 1'b0;
            fault_r <= 1'b0;
            done_r <= 1'b0;
            for (int k = 0; k < `CCSR_BUF_BYTES; k++)
            begin
                key_mem[k] <= 8'h00;
                data_mem[k] <= 8'h00;
            end
            ph_r <= CCSR_PH_CMD;
            bit_r <= 3'h0;
            sh_r <= 8'h00;
            addr_r <= 8'h00;
            wr_r <= 1'b0;
            out_r <= 8'h00;
            miso_r <= 1'b0;
            rd_cnt_r <= 5'h00;
            sclk_d_r <= 1'b0;
        end
        else
        begin
            op_r <= op_nxt;
            dir_r <= dir_nxt;
            fault_r <= fault_nxt;
            done_r <= done_nxt;
            if (buf_wr && op_r == CCSR_OP_KEY)
                key_mem[buf_idx] <= rx_byte;
            else if (buf_wr)
                data_mem[buf_idx] <= rx_byte;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            addr_r <= addr_nxt;
            wr_r <= wr_nxt;
            out_r <= out_nxt;
            miso_r <= miso_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            sclk_d_r <= sclk_d_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign MISO = miso_r;
    // Drive the serial output only while selected
    assign MISO_OE = !sel_n_s;
    assign CIPHER_OP = op_r;
    assign CIPHER_DECRYPT = dir_r && (op_r == CCSR_OP_ECB);
    assign CIPHER_BUSY = busy;
endmodule

/* File: ccsr_top_bench.sv */
// ----------------------------------------------------------------
// Bench: queued expectations, monitor on returned bytes
// ----------------------------------------------------------------
module ccsr_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rst_n;
    logic sleep;
    logic sclk;
    logic sel_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic [2:0] op;
    logic dec;
    logic busy;
    logic [7:0] rx_byte;
    logic rx_stb;
    int error_cnt = 0;
    int n_compared = 0;
    logic [8:0] exp_q[$];
    logic [7:0] cur[16];
    logic [7:0] old[16];
    logic [7:0] seed = 8'h33;

    ccsr_top DUT (.CLK(clk), .RST_N(rst_n), .SLEEP(sleep), .SCLK(sclk), .SEL_N(sel_n),
        .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .CIPHER_OP(op),
        .CIPHER_DECRYPT(dec), .CIPHER_BUSY(busy));
    ccsr_host host (.CLK(clk), .MISO(miso), .SCLK(sclk), .SEL_N(sel_n), .MOSI(mosi),
        .rx_byte(rx_byte), .rx_stb(rx_stb));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Pins read mid-cycle so the edge's updates have landed
    task automatic cmp_pins(input logic [4:0] exp);
        @(negedge clk);
        cmp8({3'h0, op, dec, busy}, {3'h0, exp});
    endtask

    task automatic summarize();
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One byte; note always queued, compared only when it matters
    task automatic xb(input logic [7:0] tx, input logic care, input logic [7:0] ev);
        exp_q.push_back({care, ev});
        host.xbyte(tx);
    endtask

    task automatic open_at(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] st);
        host.open_frame();
        // Status leaves during the address byte
        xb(cmd, 1'b0, 8'h00);
        xb(a, 1'b1, st);
    endtask

    task automatic wr1(input logic [7:0] a, input logic [7:0] d, input logic [7:0] st);
        open_at(8'h40, a, st);
        xb(d, 1'b0, 8'h00);
        host.close_frame();
    endtask

    task automatic rd1(input logic [7:0] a, input logic [7:0] ev, input logic [7:0] st);
        open_at(8'h00, a, st);
        xb(8'h00, 1'b1, ev);
        host.close_frame();
    endtask

    task automatic nap();
        @(posedge clk);
        sleep <= 1'b1;
        repeat (2) @(posedge clk);
        sleep <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 800 && busy !== 1'b0; i++)
            @(posedge clk);
    endtask

    // Config, 16 block bytes, alias last; old bytes come back one late
    task automatic burst(input logic [7:0] cfg, input logic [7:0] last, input logic upd);
        open_at(8'h40, 8'h83, 8'h00);
        xb(cfg, 1'b0, 8'h00);
        for (int i = 0; i < 16; i++)
            xb(cur[i], i > 0, old[(i + 15) % 16]);
        xb(last, 1'b1, old[15]);
        host.close_frame();
        if (upd)
            old = cur;
        foreach (cur[i])
        begin
            seed = lfsr(seed);
            cur[i] = seed;
        end
    endtask

    // Bytes returned by the device against the oldest note
    always @(posedge clk)
    begin
        if (rx_stb === 1'b1 && exp_q.size() > 0)
        begin
            if (exp_q[0][8] === 1'b1)
                cmp8(rx_byte, exp_q[0][7:0]);
            void'(exp_q.pop_front());
        end
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    initial
    begin
        rst_n = 1'b0;
        sleep = 1'b0;
        foreach (old[i])
            old[i] = 8'h00;
        foreach (cur[i])
        begin
            seed = lfsr(seed);
            cur[i] = seed;
        end
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        cmp_pins(5'h00);
        rd1(8'h82, 8'h00, 8'h00);
        rd1(8'h83, 8'h00, 8'h00);
        wr1(8'h95, 8'hff, 8'h00);
        rd1(8'h95, 8'h00, 8'h00);
        // Every mode, reserved bits written high, alias used in turn
        for (int m = 0; m < 3; m++)
        begin
            wr1(m == 1 ? 8'h94 : 8'h83, {1'b0, m[2:0], 4'hf}, 8'h00);
            cmp_pins({m[2:0], m == 0, 1'b0});
            rd1(m == 2 ? 8'h94 : 8'h83, {1'b0, m[2:0], 4'h8}, 8'h00);
        end
        wr1(8'h83, 8'h80, 8'h00);
        cmp_pins(5'h01);
        rd1(8'h82, 8'h00, 8'h00);
        wait_idle();
        cmp_pins(5'h00);
        rd1(8'h82, 8'h01, 8'h01);
        // Restart, then touch control mid-run; the host is not meant to do this
        wr1(8'h83, 8'h80, 8'h01);
        rd1(8'h82, 8'h00, 8'h00);
        rd1(8'h83, 8'h00, 8'h00);
        cmp_pins(5'h00);
        rd1(8'h82, 8'h80, 8'h80);
        nap();
        rd1(8'h82, 8'h00, 8'h00);
        // Short read of the block, then deselect
        open_at(8'h00, 8'h84, 8'h00);
        repeat (4) xb(8'h00, 1'b1, 8'h00);
        host.close_frame();
        rd1(8'h82, 8'h80, 8'h80);
        nap();
        burst(8'h10, 8'h10, 1'b0);
        burst(8'h00, 8'h00, 1'b1);
        burst(8'h00, 8'h80, 1'b1);
        cmp_pins(5'h01);
        wait_idle();
        rd1(8'h82, 8'h01, 8'h01);
        summarize();
    end
endmodule
